/* verilog/efpc_top.sv */
// earth fault permissive comparison: send, release, echo, switching and registers
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// What this block does
// R1: forward earth fault keys permissive send
// R2: release trip only with forward fault and receive
// R3: prolong send after drop, only after trip
// R4: three-terminal: send both ends, AND receives
// R5: optional per-phase send and receive circuits
// R6: no single phase identified: send all phases
// R7: phase selection only with single-pole trip select
// R8: active only when all three sources on
// R9: only the switching-off source may switch on
// R10: source switch states survive supply loss
// R11: echo on receive without local fault detection
// R12: transient blocking suppresses false releases
// R13: only forward-set stage keys the send
// R14: channel disturbance input may block supplement
// R15: one channel per direction per remote end
// R16: prolongation is a tick down-counter
module efpc_top
  import efpc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  input wire logic ef_fwd_in,
  input wire logic ef_rev_in,
  input wire logic ef_pickup_in,
  input wire logic [NPH-1:0] phase_sel_in,
  input wire logic trip_in,
  input wire logic [NPH-1:0] rx_a_in,
  input wire logic [NPH-1:0] rx_b_in,
  input wire logic chan_fail_in,
  input wire logic bin_on_in,
  input wire logic bin_off_in,
  input wire logic [2:0] nv_state_in,
  output logic [2:0] nv_state_out,
  output logic [NPH-1:0] send_a_out,
  output logic [NPH-1:0] send_b_out,
  output logic [NPH-1:0] release_out,
  output logic echo_out,
  output logic active_out,
  output logic irq_out
);
  typedef struct packed {
    logic loaded;
    logic [2:0] off;
    efpc_ctrl_t ctrl;
    logic [CNT_W-1:0] prolong;
    logic [CNT_W-1:0] tblk;
    logic [CNT_W-1:0] tb_cnt;
    logic [PRE_W-1:0] pre;
    logic tick;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic chfail;
    logic [NPH-1:0] send;
    logic [NPH-1:0] rel;
    logic echo;
    logic active;
    logic irq;
    logic [DATA_W-1:0] rdata;
  } efpc_state_t;

  efpc_state_t st_q, st_d;
  efpc_bus_t bus;
  logic fn_active;
  logic one_phase;
  logic tb_block;
  logic ch_block;
  logic [NPH-1:0] phase_key;
  logic [NPH-1:0] send_cond;
  logic [NPH-1:0] hold;
  logic [NPH-1:0] rx_ok;
  logic [NPH-1:0] rel_cond;
  logic rx_any;
  logic echo_cond;
  logic [EV_W-1:0] ev;

  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign fn_active = st_q.loaded && (st_q.off == 3'h0); // R8
  assign one_phase = $onehot(phase_sel_in);
  assign tb_block = st_q.ctrl.tb_en && (ef_rev_in || st_q.tb_cnt != '0); // R12
  assign ch_block = st_q.ctrl.chblk_en && chan_fail_in; // R14
  assign rx_any = st_q.ctrl.three_term ? |(rx_a_in | rx_b_in) : |rx_a_in; // R11
  assign echo_cond = fn_active && rx_any && !ef_pickup_in && !ef_fwd_in && !ef_rev_in; // R11

  generate
    for (genvar p = 0; p < NPH; p++) begin : g_phase
      localparam int RP = p;
      logic rxa;
      logic rxb;
      // without segregation the phase 0 channel carries the common signal
      assign rxa = st_q.ctrl.phase_seg ? rx_a_in[RP] : rx_a_in[0]; // R5 R15
      assign rxb = st_q.ctrl.phase_seg ? rx_b_in[RP] : rx_b_in[0]; // R5 R15
      assign rx_ok[p] = st_q.ctrl.three_term ? (rxa && rxb) : rxa; // R4
      // per-phase keying only when the selector really names one phase
      assign phase_key[p] = !(st_q.ctrl.phase_seg && st_q.ctrl.sp_trip && one_phase)
                            || phase_sel_in[RP]; // R6 R7
      assign send_cond[p] = fn_active && st_q.ctrl.stage_fwd && ef_fwd_in && phase_key[p]; // R1 R13
      assign rel_cond[p] = send_cond[p] && rx_ok[p] && !tb_block && !ch_block; // R2
      efpc_prolong #(.W(CNT_W)) u_prolong (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .ce_in(ce_in),
        .tick_in(st_q.tick),
        .cond_in(send_cond[p]),
        .trip_in(trip_in),
        .load_in(st_q.prolong),
        .hold_out(hold[p])
      );
    end
  endgenerate

  always_comb begin
    ev = '0;
    ev[EV_RELEASE] = |rel_cond && !(|st_q.rel);
    ev[EV_ECHO] = echo_cond && !st_q.echo;
    ev[EV_SEND] = |send_cond && !(|st_q.send);
    ev[EV_ACTIVE] = fn_active != st_q.active;
    ev[EV_CHFAIL] = chan_fail_in && !st_q.chfail;
  end

  always_comb begin
    st_d = st_q;
    st_d.loaded = 1'b1;
    // switch states come back from retained storage on the first cycle after reset
    if (!st_q.loaded) begin
      st_d.off = nv_state_in; // R10
    end
    if (st_q.pre == PRE_W'(TICK_CYCLES - 1)) begin
      st_d.pre = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.pre = st_q.pre + 1'b1;
      st_d.tick = 1'b0;
    end
    // each off flag is cleared only by its own source
    if (bin_off_in) begin
      st_d.off[SRC_BIN] = 1'b1; // R9
    end else if (bin_on_in) begin
      st_d.off[SRC_BIN] = 1'b0; // R9
    end
    if (ef_rev_in) begin
      st_d.tb_cnt = st_q.tblk; // R12
    end else if (st_q.tick && st_q.tb_cnt != '0) begin
      st_d.tb_cnt = st_q.tb_cnt - 1'b1;
    end
    st_d.rdata = '0;
    if (bus.wr) begin
      case (bus.addr)
        ADDR_CTRL: begin
          st_d.off[SRC_PARAM] = !bus.wdata[CTRL_FN_ON]; // R9
          st_d.ctrl.three_term = bus.wdata[CTRL_THREE_TERM];
          st_d.ctrl.phase_seg = bus.wdata[CTRL_PHASE_SEG];
          st_d.ctrl.sp_trip = bus.wdata[CTRL_SP_TRIP];
          st_d.ctrl.stage_fwd = bus.wdata[CTRL_STAGE_FWD];
          st_d.ctrl.chblk_en = bus.wdata[CTRL_CHBLK_EN];
          st_d.ctrl.tb_en = bus.wdata[CTRL_TB_EN];
        end
        ADDR_SYSCMD: begin
          if (bus.wdata[SYS_OFF]) begin
            st_d.off[SRC_SYS] = 1'b1; // R9
          end else if (bus.wdata[SYS_ON]) begin
            st_d.off[SRC_SYS] = 1'b0; // R9
          end
        end
        ADDR_PROLONG: st_d.prolong = bus.wdata[CNT_W-1:0];
        ADDR_TBLK: st_d.tblk = bus.wdata[CNT_W-1:0];
        ADDR_MASK: st_d.mask = bus.wdata[EV_W-1:0];
        default: ;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        ADDR_CTRL: st_d.rdata = {25'h0, st_q.ctrl, !st_q.off[SRC_PARAM]};
        ADDR_SYSCMD: st_d.rdata = {31'h0, !st_q.off[SRC_SYS]};
        ADDR_PROLONG: st_d.rdata = {16'h0, st_q.prolong};
        ADDR_TBLK: st_d.rdata = {16'h0, st_q.tblk};
        ADDR_STATUS: st_d.rdata = {27'h0, st_q.status};
        ADDR_MASK: st_d.rdata = {27'h0, st_q.mask};
        ADDR_STATE: st_d.rdata = {19'h0, st_q.tb_cnt != '0, st_q.chfail, st_q.echo, st_q.rel,
                                  st_q.send, st_q.off, st_q.active};
        default: st_d.rdata = '0;
      endcase
    end
    // read clears, but an event in the same cycle still lands
    if (bus.rd && bus.addr == ADDR_STATUS) begin
      st_d.status = ev;
    end else begin
      st_d.status = st_q.status | ev;
    end
    st_d.chfail = chan_fail_in;
    st_d.send = send_cond | hold; // R1 R3 R4
    st_d.rel = rel_cond; // R2
    st_d.echo = echo_cond; // R11
    st_d.active = fn_active;
    st_d.irq = |(st_d.status & st_q.mask);
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= '0;
      st_q.ctrl <= CTRL_RST;
      st_q.prolong <= PROLONG_RST;
      st_q.tblk <= TBLK_RST;
      st_q.mask <= MASK_RST;
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  assign rdata_out = st_q.rdata;
  assign nv_state_out = st_q.off;
  assign send_a_out = st_q.send;
  assign send_b_out = st_q.send; // R4 R15
  assign release_out = st_q.rel;
  assign echo_out = st_q.echo;
  assign active_out = st_q.active;
  assign irq_out = st_q.irq;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_trip_then_drop;
    ce_in && send_cond[0] && trip_in ##1 ce_in && !send_cond[0] && st_q.prolong != '0;
  endsequence

  a_send_keyed: assert property (ce_in && send_cond[0] |=> send_a_out[0] && send_b_out[0]) // R1
    else $error("forward fault did not key send");
  a_release_needs: assert property (ce_in && !(ef_fwd_in && rx_ok[0]) |=> !release_out[0]) // R2
    else $error("release without forward fault and receive");
  a_prolong_hold: assert property (s_trip_then_drop |=> send_a_out[0]) // R3 R16
    else $error("send not prolonged after trip");
  a_no_prolong: assert property (ce_in && !send_cond[0] && !hold[0] |=> !send_a_out[0]) // R3
    else $error("send held without prolongation");
  a_three_and: assert property (ce_in && st_q.ctrl.three_term && !rx_b_in[0] |=> !release_out[0]) // R4
    else $error("three-terminal release without both receives");
  a_all_phases: assert property (ce_in && send_cond[0] && !one_phase |=> send_a_out == 3'h7) // R6
    else $error("unidentified phase did not send all phases");
  a_inactive_quiet: assert property (ce_in && !fn_active |=> release_out == 3'h0 && !echo_out) // R8
    else $error("inactive function released or echoed");
  a_off_sticky: assert property (ce_in && st_q.loaded && st_q.off[SRC_SYS] && !(bus.wr && bus.addr == ADDR_SYSCMD)
                                 |=> st_q.off[SRC_SYS]) // R9
    else $error("system off cleared by another source");
  a_echo_keyed: assert property (ce_in && echo_cond |=> echo_out) // R11
    else $error("echo not raised");
  a_transient: assert property (ce_in && ef_rev_in && st_q.ctrl.tb_en |=> release_out == 3'h0) // R12
    else $error("release during transient blocking");
  a_rev_nosend: assert property (ce_in && !ef_fwd_in && hold == 3'h0 |=> send_a_out == 3'h0) // R13
    else $error("send without forward fault");
endmodule // efpc_top

/* verilog/efpc_pkg.sv */
// shared constants and types for the earth fault permissive comparison block
package efpc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int PRE_W = 24;
  localparam int NPH = 3;
  localparam int EV_W = 5;
  // register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SYSCMD = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PROLONG = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_TBLK = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h18;
  // control and system command field positions
  localparam int CTRL_FN_ON = 0;
  localparam int CTRL_THREE_TERM = 1;
  localparam int CTRL_PHASE_SEG = 2;
  localparam int CTRL_SP_TRIP = 3;
  localparam int CTRL_STAGE_FWD = 4;
  localparam int CTRL_CHBLK_EN = 5;
  localparam int CTRL_TB_EN = 6;
  localparam int SYS_ON = 0;
  localparam int SYS_OFF = 1;
  // switching source index in the off flags
  localparam int SRC_PARAM = 0;
  localparam int SRC_SYS = 1;
  localparam int SRC_BIN = 2;
  // status event bits
  localparam int EV_RELEASE = 0;
  localparam int EV_ECHO = 1;
  localparam int EV_SEND = 2;
  localparam int EV_ACTIVE = 3;
  localparam int EV_CHFAIL = 4;
  // timing
  localparam int CLK_NS = 5;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam logic [CNT_W-1:0] PROLONG_RST = 16'h0000;
  localparam logic [CNT_W-1:0] TBLK_RST = 16'h0000;
  localparam logic [EV_W-1:0] MASK_RST = 5'h00;

  typedef struct packed {
    logic tb_en;
    logic chblk_en;
    logic stage_fwd;
    logic sp_trip;
    logic phase_seg;
    logic three_term;
  } efpc_ctrl_t;

  localparam efpc_ctrl_t CTRL_RST = '{tb_en: 1'b1, chblk_en: 1'b1, stage_fwd: 1'b1,
                                      sp_trip: 1'b0, phase_seg: 1'b0, three_term: 1'b0};

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } efpc_bus_t;
endpackage

/* verilog/efpc_prolong.sv */
// send prolongation down-counter for one phase
`timescale 1ns/1ps
module efpc_prolong
  import efpc_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic tick_in,
  input wire logic cond_in,
  input wire logic trip_in,
  input wire logic [W-1:0] load_in,
  output logic hold_out
);
  typedef struct packed {
    logic prev;
    logic trip_seen;
    logic [W-1:0] cnt;
  } efpc_prol_t;

  efpc_prol_t st_q, st_d;
  logic fall;

  assign fall = st_q.prev && !cond_in;
  // bridge the cycle in which the counter loads so send does not drop for one cycle when the trip was seen before the drop
  assign hold_out = (st_q.cnt != '0) || (fall && st_q.trip_seen && load_in != '0);

  always_comb begin
    st_d = st_q;
    st_d.prev = cond_in;
    if (cond_in) begin
      st_d.trip_seen = st_q.trip_seen || trip_in;
      st_d.cnt = '0;
    end else if (fall) begin
      st_d.trip_seen = 1'b0;
      if (st_q.trip_seen || trip_in) begin
        st_d.cnt = load_in; // R3 R16
      end
    end else if (tick_in && st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - 1'b1; // R16
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= '0;
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end
endmodule // efpc_prolong

/* tb/efpc_remote.sv */
// far-end relay model: keys its permissive send on its own forward fault
`timescale 1ns/1ps
module efpc_remote
  import efpc_pkg::*;
#(
  parameter int LAT = 1
) (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic fwd_in,
  input wire logic [NPH-1:0] ph_in,
  output logic [NPH-1:0] rx_out
);
  // latency stands for the channel transit time; larger values model a slow link
  logic [NPH-1:0] pipe_q [LAT];
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < LAT; i++) pipe_q[i] <= 3'h0;
    end else begin
      pipe_q[0] <= fwd_in ? ph_in : 3'h0;
      for (int i = 1; i < LAT; i++) pipe_q[i] <= pipe_q[i-1];
    end
  end
  assign rx_out = pipe_q[LAT-1];
endmodule // efpc_remote

/* tb/efpc_top_bench.sv */
// self-checking bench for the earth fault permissive comparison block
`timescale 1ns/1ps
module efpc_top_bench
  import efpc_pkg::*;
;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic wr = 1'b0, rd = 1'b0, fwd = 1'b0, rev = 1'b0, pick = 1'b0, trip = 1'b0;
  logic chf = 1'b0, bon = 1'b0, boff = 1'b0, fa = 1'b0, fb = 1'b0;
  logic [2:0] psel = 3'h0, rph = 3'h7, rxa, rxb, nvo, snda, sndb, rel;
  logic echo, act, irq;
  logic ce = 1'b1;
  logic [2:0] nvi = 3'h0;
  int fail_count = 0;
  int checks_done = 0;

  initial forever #2.5 mclk_in = ~mclk_in;

  efpc_top #(.TICK_CYCLES(4)) u_dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .ce_in(ce),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .ef_fwd_in(fwd), .ef_rev_in(rev), .ef_pickup_in(pick), .phase_sel_in(psel),
    .trip_in(trip), .rx_a_in(rxa), .rx_b_in(rxb), .chan_fail_in(chf), .bin_on_in(bon),
    .bin_off_in(boff), .nv_state_in(nvi), .nv_state_out(nvo), .send_a_out(snda),
    .send_b_out(sndb), .release_out(rel), .echo_out(echo), .active_out(act), .irq_out(irq));
  efpc_remote #(.LAT(1)) u_rem_a (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .fwd_in(fa),
    .ph_in(rph), .rx_out(rxa));
  efpc_remote #(.LAT(3)) u_rem_b (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .fwd_in(fb),
    .ph_in(rph), .rx_out(rxb));

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // hang guard: every wait below is a fixed count, this only catches a stuck run
  initial begin
    repeat (20000) @(posedge mclk_in);
    fail_count++;
    stop_test();
  end

  initial begin
    cyc(6);
    reset_n_in <= 1'b1;
    cyc(3);
    rd_reg(ADDR_CTRL, d);
    chk("ctrl", 32'h71, d);
    chk("active", 32'h1, act);
    rd_reg(8'hfc, d);
    chk("unmapped", 32'h0, d);
    rd_reg(ADDR_STATUS, d);
    wr_reg(ADDR_MASK, 32'h4);
    wr_reg(ADDR_PROLONG, 32'h3);
    wr_reg(ADDR_TBLK, 32'h2);
    fa <= 1'b1;
    fwd <= 1'b1;
    cyc(4);
    chk("send", 32'h7, snda);
    chk("release", 32'h7, rel);
    chk("irq", 32'h1, irq);
    rd_reg(ADDR_STATUS, d);
    chk("st_send", 32'h1, d[EV_SEND]);
    cyc(2);
    chk("irq_clr", 32'h0, irq);
    fwd <= 1'b0;
    cyc(3);
    chk("no_prolong", 32'h0, snda);
    rev <= 1'b1;
    cyc(3);
    chk("rev_send", 32'h0, snda);
    fwd <= 1'b1;
    trip <= 1'b1;
    cyc(3);
    chk("rev_rel", 32'h0, rel);
    rev <= 1'b0;
    cyc(3);
    chk("tblk_rel", 32'h0, rel);
    fwd <= 1'b0;
    trip <= 1'b0;
    cyc(6);
    chk("prolong_on", 32'h7, snda);
    cyc(10);
    chk("prolong_off", 32'h0, snda);
    fwd <= 1'b1;
    fa <= 1'b0;
    cyc(4);
    chk("no_rx_rel", 32'h0, rel);
    fa <= 1'b1;
    chf <= 1'b1;
    cyc(4);
    chk("chfail_rel", 32'h0, rel);
    chf <= 1'b0;
    wr_reg(ADDR_CTRL, 32'h73);
    cyc(4);
    chk("send_b", 32'h7, sndb);
    chk("and_rel", 32'h0, rel);
    fb <= 1'b1;
    cyc(6);
    chk("both_rel", 32'h7, rel);
    wr_reg(ADDR_CTRL, 32'h7d);
    psel <= 3'h1;
    rph <= 3'h1;
    cyc(6);
    chk("ph_send", 32'h1, snda);
    chk("ph_rel", 32'h1, rel);
    psel <= 3'h3;
    cyc(3);
    chk("ph_all", 32'h7, snda);
    wr_reg(ADDR_CTRL, 32'h75);
    psel <= 3'h1;
    cyc(3);
    chk("no_sp_trip", 32'h7, snda);
    wr_reg(ADDR_CTRL, 32'h73);
    rph <= 3'h7;
    fwd <= 1'b0;
    fa <= 1'b0;
    cyc(6);
    chk("echo_one", 32'h1, echo);
    pick <= 1'b1;
    cyc(3);
    chk("echo_pick", 32'h0, echo);
    pick <= 1'b0;
    wr_reg(ADDR_CTRL, 32'h71);
    wr_reg(ADDR_SYSCMD, 32'h3);
    cyc(3);
    chk("sys_off", 32'h0, act);
    chk("nv_sys", 32'h2, nvo);
    wr_reg(ADDR_CTRL, 32'h71);
    bon <= 1'b1;
    cyc(3);
    chk("other_on", 32'h0, act);
    bon <= 1'b0;
    wr_reg(ADDR_SYSCMD, 32'h1);
    cyc(3);
    chk("sys_on", 32'h1, act);
    boff <= 1'b1;
    cyc(3);
    chk("bin_off", 32'h0, act);
    chk("nv_bin", 32'h4, nvo);
    boff <= 1'b0;
    bon <= 1'b1;
    cyc(3);
    chk("bin_on", 32'h1, act);
    wr_reg(ADDR_CTRL, 32'h70);
    fwd <= 1'b1;
    cyc(3);
    chk("param_off", 32'h0, act);
    chk("off_send", 32'h0, snda);
    rd_reg(ADDR_CTRL, d);
    chk("ctrl_off", 32'h70, d);
    rd_reg(ADDR_STATE, d);
    chk("state", 32'h2, d);
    // second reset: the retained flags must come back through the storage port
    nvi <= 3'h2;
    reset_n_in <= 1'b0;
    cyc(2);
    chk("rst_send", 32'h0, snda);
    reset_n_in <= 1'b1;
    cyc(3);
    chk("nv_load", 32'h2, nvo);
    chk("nv_act", 32'h0, act);
    ce <= 1'b0;
    wr_reg(ADDR_MASK, 32'h1f);
    ce <= 1'b1;
    rd_reg(ADDR_MASK, d);
    chk("ce_freeze", 32'h0, d);
    wr_reg(ADDR_SYSCMD, 32'h1);
    cyc(3);
    chk("nv_sys_on", 32'h1, act);
    stop_test();
  end
endmodule // efpc_top_bench
